//--- rtl/ctc_pkg.sv
// constants for the control timer counter value register block
package ctc_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET  = 8'h34;

  // counter geometry
  localparam int          COUNT_WIDTH = 24;
  localparam logic [23:0] COUNT_FULL_MASK = 24'hFFFFFF;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;

  // dither mode encodings held in the control register
  localparam logic [1:0] MODE_NO_DITHER         = 2'h0;
  localparam logic [1:0] MODE_FOUR_BIT_DITHER   = 2'h1;
  localparam logic [1:0] MODE_FIVE_BIT_DITHER   = 2'h2;
  localparam logic [1:0] MODE_SIX_BIT_DITHER    = 2'h3;

  // reserved low bits per dither layout
  localparam logic [4:0] SHIFT_NO_DITHER       = 5'h00;
  localparam logic [4:0] SHIFT_FOUR_BIT_DITHER = 5'h04;
  localparam logic [4:0] SHIFT_FIVE_BIT_DITHER = 5'h05;
  localparam logic [4:0] SHIFT_SIX_BIT_DITHER  = 5'h06;

  // control register fields
  localparam int          CTRL_WP_BIT     = 0;
  localparam int          CTRL_MODE_LSB   = 1;
  localparam int          CTRL_EN_BIT     = 3;
  localparam logic [31:0] CTRL_RESET      = 32'h00000000;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000000F;

  // status register fields
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_WPERR_BIT = 1;

  // crossing into the counter clock domain
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          SYNC_TIME_NS  = 150;
  localparam int          SYNC_CYCLES_INT = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SYNC_CYCLES   = 4'(SYNC_CYCLES_INT < 1 ? 1 : SYNC_CYCLES_INT);

endpackage

//--- rtl/count_sync.sv
// sequencer that paces one access across to the counter clock domain
`timescale 1ns/1ps
module count_sync
  import ctc_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // request and completion
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);

  typedef enum {sync_idle, sync_run} sync_state_t;

  sync_state_t state;
  sync_state_t next_state;
  logic [3:0]  cycles;
  logic [3:0]  next_cycles;

  always_comb begin
    next_state  = state;
    next_cycles = cycles;
    case (state)
      sync_idle: begin
        if (i_start) begin
          next_state  = sync_run;
          next_cycles = 4'h1;
        end
      end
      sync_run: begin
        if (cycles == SYNC_CYCLES) begin
          next_state  = sync_idle;
          next_cycles = 4'h0;
        end else begin
          next_cycles = cycles + 4'h1;
        end
      end
      default: begin
        next_state  = sync_idle;
        next_cycles = 4'h0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state  <= sync_idle;
      cycles <= 4'h0;
    end else begin
      state  <= next_state;
      cycles <= next_cycles;
    end
  end

  assign o_busy = (state == sync_run);
  assign o_done = (state == sync_run) && (cycles == SYNC_CYCLES);

endmodule // count_sync

//--- rtl/counter_value_regs.sv
// apb slave holding the timer counter value register in all dither layouts
//
// Overview of operation
// - without dither the whole counter lives in bits 23:0, read-write
// - count field width follows the counter width, masked per layout
// - four-bit dither: count in bits 23:4, bits 3:0 read-only zero
// - five-bit dither: count in bits 23:5, bits 4:0 read-only zero
// - bits 31:24 read zero; software writes zeros there
// - counter resets to zero; count bits read-write in every layout
// - counter accesses pass the clock crossing; protected writes are blocked
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module counter_value_regs
  import ctc_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // counting
  input  wire logic        i_count_step,
  output logic [23:0]      o_count,
  output logic [1:0]       o_dither_mode,
  output logic             o_sync_busy
);

  // counter accesses other than refused writes wait in sync for the crossing, then answer for one cycle in done
  typedef enum {bus_idle, bus_sync, bus_done} bus_state_t;

  // registered state
  bus_state_t  state;
  bus_state_t  next_state;
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [23:0] count;
  logic [23:0] next_count;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        wp_error;
  logic        next_wp_error;

  // combinational decode
  logic        setup;
  logic        count_setup;
  logic        access;
  logic        sel_ctrl;
  logic        sel_status;
  logic        sel_count;
  logic        unmapped;
  logic        protect;
  logic        count_enable;
  logic [1:0]  mode;
  logic [4:0]  shift;
  logic [23:0] field_mask;
  logic [23:0] step_value;
  logic        sync_start;
  logic        sync_busy;
  logic        sync_done;
  logic        count_commit;
  logic        blocked_write;
  logic        immediate_answer;
  logic        answer_error;

  // counter field views and write strobes
  logic        count_write;
  logic        ctrl_write;
  logic        status_clear;
  logic [23:0] count_view;
  logic [23:0] write_field;
  logic [23:0] step_count;
  logic [31:0] status_word;

  // address decode
  assign setup      = i_psel && !i_penable;
  assign access     = i_psel && i_penable;
  assign sel_ctrl   = (i_paddr == CTRL_OFFSET);
  assign sel_status = (i_paddr == STATUS_OFFSET);
  assign sel_count  = (i_paddr == COUNT_OFFSET);
  assign unmapped   = !(sel_ctrl || sel_status || sel_count);
  assign count_setup = setup && sel_count;
  assign count_write = sel_count && i_pwrite;

  // control fields
  assign protect      = ctrl[CTRL_WP_BIT];
  assign mode         = ctrl[CTRL_MODE_LSB +: 2];
  assign count_enable = ctrl[CTRL_EN_BIT];

  // layout selection by dither mode
  always_comb begin
    case (mode)
      MODE_NO_DITHER: begin
        shift = SHIFT_NO_DITHER;
      end
      MODE_FOUR_BIT_DITHER: begin
        shift = SHIFT_FOUR_BIT_DITHER;
      end
      MODE_FIVE_BIT_DITHER: begin
        shift = SHIFT_FIVE_BIT_DITHER;
      end
      MODE_SIX_BIT_DITHER: begin
        shift = SHIFT_SIX_BIT_DITHER;
      end
      default: begin
        shift = SHIFT_NO_DITHER;
      end
    endcase
  end

  // field holds exactly the counter bits
  // a bit belongs to the count once it sits at or above the layout shift
  for (genvar b = 0; b < COUNT_WIDTH; b++) begin : g_field_bit
    assign field_mask[b] = (5'(b) >= shift);
  end
  // one count step moves the lowest field bit
  assign step_value = 24'h000001 << shift;

  // the read view never carries bits above the counter
  assign count_view  = count & field_mask;
  // write bits above the counter and below the field are dropped
  assign write_field = i_pwdata[COUNT_WIDTH-1:0] & field_mask;
  // stepping at the field lsb keeps dither bits out of the count
  assign step_count  = count + step_value;

  // protected counter writes are refused at once
  assign blocked_write = count_write && protect;

  // counter reads and unrefused counter writes start a crossing in the setup phase
  // starting at setup hides one cycle of the crossing inside the setup phase
  assign sync_start = (state == bus_idle) && count_setup && !blocked_write;

  // registers other than the counter answer in the first access cycle
  assign immediate_answer = (state == bus_idle) && access;
  // unmapped addresses and refused counter writes answer with an error
  assign answer_error     = unmapped || blocked_write;

  // bus sequencing
  always_comb begin
    next_state = state;
    case (state)
      bus_idle: begin
        // only counter accesses leave idle
        if (sync_start) begin
          next_state = bus_sync;
        end
      end
      bus_sync: begin
        // hold the access until the sequencer reports the end
        if (sync_done) begin
          next_state = bus_done;
        end
      end
      bus_done: begin
        // one answer cycle, then back to idle
        next_state = bus_idle;
      end
      default: begin
        next_state = bus_idle;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= bus_idle;
    end else begin
      state <= next_state;
    end
  end

  // handshake answers
  // counter accesses never fail once their crossing has started
  assign o_pready  = immediate_answer || (state == bus_done);
  assign o_pslverr = immediate_answer && answer_error;

  // write lands only once the crossing has completed
  assign count_commit = (state == bus_done) && access && count_write;
  assign ctrl_write   = immediate_answer && i_pwrite && sel_ctrl;
  assign status_clear = immediate_answer && i_pwrite && sel_status && i_pwdata[STATUS_WPERR_BIT];

  // control register, always writable so protection can be lifted
  // reserved control bits are masked on write and read back as zero
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_write) begin
      next_ctrl = i_pwdata & CTRL_WRITE_MASK;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // sticky flag for refused writes; a new refusal beats a clear
  // clearing needs a one written to the flag bit
  always_comb begin
    next_wp_error = wp_error;
    if (status_clear) begin
      next_wp_error = 1'b0;
    end
    if (immediate_answer && blocked_write) begin
      next_wp_error = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_error <= 1'b0;
    end else begin
      wp_error <= next_wp_error;
    end
  end

  // counter value
  always_comb begin
    next_count = count;
    // a write in the same cycle as a step wins and the step is lost
    if (count_commit) begin
      next_count = write_field;
    end else if (count_enable && i_count_step) begin
      next_count = step_count;
    end
    // reserved low bits hold data only in the one cycle after a layout change
    next_count = next_count & field_mask;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count <= COUNT_RESET[COUNT_WIDTH-1:0];
    end else begin
      count <= next_count;
    end
  end

  // status word; busy is seen at setup, so a lone master always reads it clear
  always_comb begin
    status_word                   = 32'h00000000;
    status_word[STATUS_BUSY_BIT]  = sync_busy;
    status_word[STATUS_WPERR_BIT] = wp_error;
  end

  // read data; the counter snapshot is taken as the crossing ends
  always_comb begin
    next_rdata = rdata;
    // control and status answer at once, so their word is latched at setup
    if ((state == bus_idle) && setup) begin
      // anything not decoded reads as zero
      next_rdata = 32'h00000000;
      if (sel_ctrl) begin
        next_rdata = ctrl;
      end
      if (sel_status) begin
        next_rdata = status_word;
      end
    end
    if ((state == bus_sync) && sync_done) begin
      next_rdata = {8'h00, count_view};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // crossing sequencer
  // fixed length; the counter shares this clock, so no data word crosses domains
  count_sync u_count_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (sync_start),
    .o_busy  (sync_busy),
    .o_done  (sync_done)
  );

  // outputs
  assign o_prdata      = rdata;
  assign o_count       = count;
  assign o_dither_mode = mode;
  assign o_sync_busy   = sync_busy;

endmodule // counter_value_regs

//--- tb/ctc_chk.sv
// port assertions for the counter value register block
`timescale 1ns/1ps
module ctc_chk
  import ctc_pkg::*;
(
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // counting
  input wire logic        i_count_step,
  input wire logic [23:0] o_count,
  input wire logic [1:0]  o_dither_mode,
  input wire logic        o_sync_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  function automatic logic [23:0] fmask(input logic [1:0] m);
    return (m == 2'h0) ? 24'hFFFFFF : (24'hFFFFFF << ({3'h0, m} + 5'h03));
  endfunction

  a_four_bit_dither_mode_low: assert property (o_dither_mode == 2'h1 && $past(o_dither_mode) == 2'h1 |-> o_count[3:0] == 4'h0)
    else $error("four-bit layout low bits set");
  a_five_bit_dither_mode_low: assert property (o_dither_mode == 2'h2 && $past(o_dither_mode) == 2'h2 |-> o_count[4:0] == 5'h00)
    else $error("five-bit layout low bits set");
  a_six_bit_dither_mode_low: assert property (o_dither_mode == 2'h3 && $past(o_dither_mode) == 2'h3 |-> o_count[5:0] == 6'h00)
    else $error("six-bit layout low bits set");
  a_top_zero: assert property (o_prdata[31:24] == 8'h00)
    else $error("read data top byte not zero");
  a_read_sync: assert property (i_psel && !i_penable && !i_pwrite && i_paddr == 8'h34 |=> !o_pready [*3] ##1 o_pready)
    else $error("count read not three wait states");
  a_busy_span: assert property (i_psel && !i_penable && !i_pwrite && i_paddr == 8'h34 |=> o_sync_busy [*3] ##1 !o_sync_busy)
    else $error("crossing busy span wrong");
  a_write_store: assert property (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h34 && !o_pslverr
    |=> o_count == ($past(i_pwdata[23:0]) & fmask(o_dither_mode)))
    else $error("count write stored wrong value");
  a_reset_clear: assert property ($past(i_rst) |-> o_count == 24'h0 && o_prdata == 32'h0)
    else $error("count not zero after reset");
endmodule // ctc_chk

//--- tb/test_counter_value_regs.sv
// self-checking bench for the counter value register block
`timescale 1ns/1ps
module test_counter_value_regs;
  import ctc_pkg::*;
  logic        i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_count_step = 0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, r;
  logic        o_pready, o_pslverr, o_sync_busy, e;
  logic [23:0] o_count, v;
  logic [1:0]  o_dither_mode;
  int          n_mismatch = 0, num_checks = 0;

  always #25 i_clk = ~i_clk;

  counter_value_regs u_counter_value_regs (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_count_step(i_count_step), .o_count(o_count), .o_dither_mode(o_dither_mode),
    .o_sync_busy(o_sync_busy));

  function automatic logic [23:0] fld(input logic [1:0] m, input logic [23:0] x);
    return (m == 2'h0) ? x : x & (24'hFFFFFF << ({3'h0, m} + 5'h03));
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask

  // waits on pready under a bound; no wait-state count is assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t no pready", $time);
      end_sim();
    end
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0; i_penable <= 1'b0;
    // an idle cycle keeps the next setup from reassigning psel in this step
    @(posedge i_clk);
  endtask

  initial begin
    void'($urandom(32'h3457));
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    apb(0, 8'h34, 0); ck(r, 32'h0);
    for (int m = 0; m < 4; m++) begin
      apb(1, 8'h00, 32'h8 | (m << 1));
      ck({30'h0, o_dither_mode}, 32'(m));
      v = 24'($urandom);
      apb(1, 8'h34, {8'h00, v}); ck({31'h0, e}, 32'h0);
      apb(0, 8'h34, 0); ck(r, {8'h00, fld(2'(m), v)});
      i_count_step <= 1'b1;
      @(posedge i_clk);
      i_count_step <= 1'b0;
      apb(0, 8'h34, 0); ck(r, {8'h00, fld(2'(m), v) + (24'h1 << (m == 0 ? 0 : m + 3))});
    end
    apb(1, 8'h00, 32'h0);
    apb(1, 8'h34, 32'h00FFFFFF);
    apb(1, 8'h00, 32'h6);
    apb(0, 8'h34, 0); ck(r, 32'h00FFFFC0);
    apb(1, 8'h00, 32'h7);
    apb(1, 8'h34, 32'h0); ck({31'h0, e}, 32'h1);
    apb(0, 8'h34, 0); ck(r, 32'h00FFFFC0);
    apb(0, 8'h04, 0); ck(r, 32'h00000002);
    apb(0, 8'h20, 0); ck({31'h0, e}, 32'h1);
    ck(r, 32'h00000000);
    apb(1, 8'h04, 32'h00000002);
    apb(0, 8'h04, 0); ck(r, 32'h00000000);
    apb(1, 8'h00, 32'h00000006);
    apb(1, 8'h34, 32'h00ABCDEF); ck({31'h0, e}, 32'h0);
    apb(0, 8'h34, 0); ck(r, 32'h00ABCDC0);
    end_sim();
  end
endmodule // test_counter_value_regs

bind counter_value_regs ctc_chk u_ctc_chk (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_count_step(i_count_step), .o_count(o_count), .o_dither_mode(o_dither_mode),
  .o_sync_busy(o_sync_busy));
